// >>> hw/tcpwm_chan.sv
// one modulator channel: enable sync, counter, compare and output level
`timescale 1ns/10ps
module tcpwm_chan
#(
    parameter int CNT_W = tcpwm_pkg::CNT_W
)
(
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // selected source clock as enable pulse
    input  wire logic                tick,
    input  wire tcpwm_pkg::tcpwm_chcfg_t cfg,
    // waveform and state
    output logic                     wave,
    output logic                     running
);
    logic [CNT_W-1:0] cnt;
    logic             up;
    logic             level;

    // compare: start level before duty count, opposite level after
    assign level = (cnt < cfg.duty) ? cfg.start_level : ~cfg.start_level;

    // run flag only rises on a source tick, so the wave starts on that clock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            running <= 1'b0;
        else if (!cfg.enable)
            running <= 1'b0;
        else if (tick)
            running <= 1'b1;
    end

    // period counter, up only when left aligned, up and down when centred
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= '0;
            up  <= 1'b1;
        end
        else if (!running)
        begin
            cnt <= '0;
            up  <= 1'b1;
        end
        else if (tick)
        begin
            if (!cfg.center)
                cnt <= (cnt >= cfg.period - 1'b1) ? '0 : cnt + 1'b1;
            else if (up)
            begin
                cnt <= (cnt >= cfg.period) ? cnt - 1'b1 : cnt + 1'b1;
                up  <= (cnt < cfg.period);
            end
            else
            begin
                cnt <= (cnt == '0) ? cnt + 1'b1 : cnt - 1'b1;
                up  <= (cnt == '0);
            end
        end
    end

    // output pin: driven to start level at once on enable, low when off
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wave <= 1'b0;
        else if (!cfg.enable)
            wave <= 1'b0;
        else if (!running)
            wave <= cfg.start_level;
        else
            wave <= level;
    end

    chk_left_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        running && tick && !cfg.center && cfg.period != '0 && cnt == cfg.period - 1'b1
        && cfg.enable |=> cnt == '0)
        else $error("left aligned counter did not wrap at period");

    chk_wave_level: assert property (@(posedge hclk) disable iff (!hresetn)
        running && cfg.enable |=> wave == $past(level))
        else $error("wave does not follow duty compare");

    chk_enable_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg.enable && !running && !tick |=> !running)
        else $error("channel ran before its source clock ticked");

    chk_disable_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !cfg.enable |=> !running && !wave)
        else $error("disabled channel still active");

    chk_center_turn: assert property (@(posedge hclk) disable iff (!hresetn)
        running && cfg.enable && cfg.center && tick && up && cnt >= cfg.period
        |=> !up)
        else $error("centred counter did not turn at period");
endmodule

// >>> hw/tcpwm_ctrl.sv
// top of the two-channel modulator: bus slave, prescaler and channel pair
`timescale 1ns/10ps

module tcpwm_ctrl
#(
    parameter int CNT_W = tcpwm_pkg::CNT_W
)
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // modulated output pins
    output logic [1:0]       wave_out
);
    // ------------------------------------------------------------------
    // registers and bus state
    // ------------------------------------------------------------------
    tcpwm_pkg::tcpwm_ctrl_t pwm_channel_control;
    logic [7:0]             prescale;
    logic [15:0]            scale;
    logic [15:0]            period;
    logic [15:0]            duty;
    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic                   addr_ok;
    logic [31:0]            next_rdata;

    // prescaler state
    logic [7:0]             presc_cnt;
    logic                   presc_on;
    logic [7:0]             mask_a;
    logic [7:0]             mask_b;
    logic                   a_tick;
    logic                   b_tick;
    logic [7:0]             scl_a_cnt;
    logic [7:0]             scl_b_cnt;
    logic                   scl_a_tick;
    logic                   scl_b_tick;
    logic [1:0]             src_tick;
    logic [1:0]             running;

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------

    // zero wait states, always OKAY; unmapped reads give zero
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready;

    // capture a write address phase, data follows in the next cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // register writes; every field accepts a write at any time
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_channel_control <= tcpwm_pkg::RST_CONTROL;
            prescale            <= tcpwm_pkg::RST_PRESCALE;
            scale               <= tcpwm_pkg::RST_SCALE;
            period              <= tcpwm_pkg::RST_PERIOD;
            duty                <= tcpwm_pkg::RST_DUTY;
        end
        else if (wr_pend)
        begin
            unique case (wr_addr)
                tcpwm_pkg::OFS_CONTROL:  pwm_channel_control <= hwdata[7:0];
                tcpwm_pkg::OFS_PRESCALE: prescale <= hwdata[7:0];
                tcpwm_pkg::OFS_SCALE:    scale    <= hwdata[15:0];
                tcpwm_pkg::OFS_PERIOD:   period   <= hwdata[15:0];
                tcpwm_pkg::OFS_DUTY:     duty     <= hwdata[15:0];
                default:                 ;
            endcase
        end
    end

    // read mux, sampled at the address phase so data stands in the data phase
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            tcpwm_pkg::OFS_CONTROL:  next_rdata = {24'h000000, pwm_channel_control};
            tcpwm_pkg::OFS_PRESCALE: next_rdata = {24'h000000, prescale};
            tcpwm_pkg::OFS_SCALE:    next_rdata = {16'h0000, scale};
            tcpwm_pkg::OFS_PERIOD:   next_rdata = {16'h0000, period};
            tcpwm_pkg::OFS_DUTY:     next_rdata = {16'h0000, duty};
            tcpwm_pkg::OFS_STATUS:   next_rdata = {27'h0000000, presc_on, running, wave_out};
            default:                 next_rdata = 32'h0000_0000;
        endcase
    end

    // read data register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
            hrdata <= next_rdata;
    end

    // ------------------------------------------------------------------
    // prescaler: clocks A and B, and the scaled clocks of each
    // ------------------------------------------------------------------

    // shared counter sleeps with both channels off to save power
    assign presc_on = |pwm_channel_control.chan_output_enable;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            presc_cnt <= 8'h00;
        else if (!presc_on)
            presc_cnt <= 8'h00;
        else
            presc_cnt <= presc_cnt + 8'h01;
    end

    // divide by two to the power of the select field
    assign mask_a = 8'((9'h001 << prescale[2:0]) - 9'h001);
    assign mask_b = 8'((9'h001 << prescale[tcpwm_pkg::PRE_B_POS +: 3]) - 9'h001);
    assign a_tick = presc_on && ((presc_cnt & mask_a) == mask_a);
    assign b_tick = presc_on && ((presc_cnt & mask_b) == mask_b);

    // scaled clocks divide A and B again by scale plus one
    assign scl_a_tick = a_tick && (scl_a_cnt == scale[7:0]);
    assign scl_b_tick = b_tick && (scl_b_cnt == scale[15:8]);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            scl_a_cnt <= 8'h00;
        else if (!presc_on || scl_a_tick)
            scl_a_cnt <= 8'h00;
        else if (a_tick)
            scl_a_cnt <= scl_a_cnt + 8'h01;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            scl_b_cnt <= 8'h00;
        else if (!presc_on || scl_b_tick)
            scl_b_cnt <= 8'h00;
        else if (b_tick)
            scl_b_cnt <= scl_b_cnt + 8'h01;
    end

    // source choice; a switch mid-period simply changes the tick rate,
    // so one pulse may come out short or long
    assign src_tick[0] = pwm_channel_control.chan_clock_select[0] ? scl_a_tick : a_tick;
    assign src_tick[1] = pwm_channel_control.chan_clock_select[1] ? scl_b_tick : b_tick;

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < tcpwm_pkg::CHANS; ch++)
        begin : g_chan
            tcpwm_pkg::tcpwm_chcfg_t cfg;

            // polarity is read live, so a change applies from the next compare
            assign cfg.enable      = pwm_channel_control.chan_output_enable[ch];
            assign cfg.start_level = pwm_channel_control.start_level_select[ch];
            assign cfg.center      = pwm_channel_control.center_align_select[ch];
            assign cfg.period      = period[ch*8 +: 8];
            assign cfg.duty        = duty[ch*8 +: 8];

            tcpwm_chan #(.CNT_W(CNT_W)) u_chan
            (
                .hclk    (hclk),
                .hresetn (hresetn),
                .tick    (src_tick[ch]),
                .cfg     (cfg),
                .wave    (wave_out[ch]),
                .running (running[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_ctrl_write;
        wr_pend && wr_addr == tcpwm_pkg::OFS_CONTROL;
    endsequence

    chk_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
        s_ctrl_write |=> pwm_channel_control == $past(hwdata[7:0]))
        else $error("control write not taken");

    chk_presc_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        !presc_on |-> (!a_tick && !b_tick) ##1 (presc_cnt == 8'h00))
        else $error("prescaler runs with both channels off");

    chk_presc_run: assert property (@(posedge hclk) disable iff (!hresetn)
        presc_on ##1 presc_on |-> presc_cnt == $past(presc_cnt) + 8'h01)
        else $error("prescaler stalled while a channel is on");

    chk_src_sel0: assert property (@(posedge hclk) disable iff (!hresetn)
        pwm_channel_control.chan_clock_select[0] && a_tick && scl_a_cnt != scale[7:0]
        |-> !src_tick[0])
        else $error("channel 0 ticked from clock A while scaled A chosen");

    chk_src_sel1: assert property (@(posedge hclk) disable iff (!hresetn)
        !pwm_channel_control.chan_clock_select[1] && b_tick |-> src_tick[1])
        else $error("channel 1 missed a clock B tick");

    chk_chan_indep: assert property (@(posedge hclk) disable iff (!hresetn)
        !pwm_channel_control.chan_output_enable[1] |=> !running[1] && !wave_out[1])
        else $error("channel 1 active while disabled");

    chk_bus_read: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite |=> hrdata == $past(next_rdata))
        else $error("read data not presented in data phase");
endmodule

// >>> hw/tcpwm_pkg.sv
// package: register map, field layouts and carrier types of the two-channel modulator
package tcpwm_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_PRESCALE = 8'h04;
    localparam logic [7:0] OFS_SCALE    = 8'h08;
    localparam logic [7:0] OFS_PERIOD   = 8'h0C;
    localparam logic [7:0] OFS_DUTY     = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int          CHANS        = 2;
    localparam int          CNT_W        = 8;
    localparam int          PRE_B_POS    = 4;
    localparam logic [7:0]  RST_CONTROL  = 8'h00;
    localparam logic [7:0]  RST_PRESCALE = 8'h00;
    localparam logic [15:0] RST_SCALE    = 16'h0000;
    localparam logic [15:0] RST_PERIOD   = 16'hFFFF;
    localparam logic [15:0] RST_DUTY     = 16'h8080;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] center_align_select;
        logic [1:0] chan_clock_select;
        logic [1:0] start_level_select;
        logic [1:0] chan_output_enable;
    } tcpwm_ctrl_t;

    // per-channel settings handed to a channel counter
    typedef struct packed {
        logic             enable;
        logic             start_level;
        logic             center;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] duty;
    } tcpwm_chcfg_t;

endpackage

// >>> tb/tcpwm_ctrl_tb_top.sv
// testbench: register access, waveform shape per mode and enable timing of the modulator
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
        bad_count++; \
        $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
end

module tcpwm_ctrl_tb_top;
    // ------------------------------------------------------------------
    // signals and tables
    // ------------------------------------------------------------------
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [1:0]  wave_out;
    logic        clr;
    logic        win;
    logic [7:0]  rise_cnt [2];
    logic [7:0]  high_cnt [2];
    logic [31:0] rd;
    int          bad_count;
    int          checks_done;

    // control values and expected {rises0, highs0, rises1, highs1} over 48 cycles
    // period 4, duty 1, scaled clocks at half rate
    localparam logic [7:0]  CTL [6] = '{8'h07, 8'hC3, 8'h13, 8'h23, 8'h01, 8'h0E};
    localparam logic [31:0] EXP [6] = '{32'h0C0C0C24, 32'h062A062A, 32'h06240C24,
                                        32'h0C240624, 32'h0C240000, 32'h00000C0C};

    tcpwm_ctrl dut
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wave_out  (wave_out)
    );

    tcpwm_load load
    (
        .hclk     (hclk),
        .wave_out (wave_out),
        .clr      (clr),
        .win      (win),
        .rise_cnt (rise_cnt),
        .high_cnt (high_cnt)
    );

    // free-running bus clock, 50 ns period
    always #25 hclk = ~hclk;

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // bounded wait for hready; a slave that never answers ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                bad_count++;
                print_verdict();
            end
            @(posedge hclk);
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] v;
        bus_xfer(1'b0, a, 32'h00000000, v);
        `CHK(nm, ex, v)
        `CHK("response", 1'b0, hresp)
    endtask

    // clear the load counters, then open the window for n samples
    task automatic measure(input int n);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        win <= 1'b1;
        repeat (n) @(posedge hclk);
        win <= 1'b0;
        @(posedge hclk);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        clr = 1'b1;
        win = 1'b0;
        bad_count = 0;
        checks_done = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, unmapped read and ignored unmapped write
        rd_chk(tcpwm_pkg::OFS_CONTROL, 32'h00000000, "control reset");
        rd_chk(tcpwm_pkg::OFS_PERIOD, 32'h0000FFFF, "period reset");
        rd_chk(tcpwm_pkg::OFS_DUTY, 32'h00008080, "duty reset");
        rd_chk(tcpwm_pkg::OFS_STATUS, 32'h00000000, "status reset");
        bus_xfer(1'b1, 8'h18, 32'hFFFFFFFF, rd);
        rd_chk(8'h18, 32'h00000000, "unmapped");
        // short period and duty, scaled clocks at half the base rate
        bus_xfer(1'b1, tcpwm_pkg::OFS_PERIOD, 32'h00000404, rd);
        bus_xfer(1'b1, tcpwm_pkg::OFS_DUTY, 32'h00000101, rd);
        bus_xfer(1'b1, tcpwm_pkg::OFS_SCALE, 32'h00000101, rd);
        // every control bit set somewhere, rewritten while channels run
        for (int i = 0; i < 6; i++)
        begin
            bus_xfer(1'b1, tcpwm_pkg::OFS_CONTROL, {24'h000000, CTL[i]}, rd);
            rd_chk(tcpwm_pkg::OFS_CONTROL, {24'h000000, CTL[i]}, "control");
            repeat (24) @(posedge hclk);
            measure(48);
            `CHK("wave counts", EXP[i], {rise_cnt[0], high_cnt[0], rise_cnt[1], high_cnt[1]})
        end
        // slow source: output shows start level at once, waveform waits for a tick
        bus_xfer(1'b1, tcpwm_pkg::OFS_CONTROL, 32'h00000000, rd);
        // channel state settles one cycle after the control write lands
        repeat (2) @(posedge hclk);
        rd_chk(tcpwm_pkg::OFS_STATUS, 32'h00000000, "status idle");
        bus_xfer(1'b1, tcpwm_pkg::OFS_PRESCALE, 32'h00000007, rd);
        bus_xfer(1'b1, tcpwm_pkg::OFS_DUTY, 32'h00000000, rd);
        bus_xfer(1'b1, tcpwm_pkg::OFS_CONTROL, 32'h00000005, rd);
        repeat (2) @(posedge hclk);
        rd_chk(tcpwm_pkg::OFS_STATUS, 32'h00000011, "status waiting");
        repeat (140) @(posedge hclk);
        rd_chk(tcpwm_pkg::OFS_STATUS, 32'h00000014, "status running");
        bus_xfer(1'b1, tcpwm_pkg::OFS_CONTROL, 32'h00000000, rd);
        repeat (2) @(posedge hclk);
        rd_chk(tcpwm_pkg::OFS_STATUS, 32'h00000000, "status stopped");
        print_verdict();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge hclk);
        bad_count++;
        print_verdict();
    end
endmodule

// >>> tb/tcpwm_load.sv
// external load model: counts rising edges and high cycles on each waveform pin
`timescale 1ns/10ps
module tcpwm_load
(
    // clock
    input  wire logic       hclk,
    // pins and measuring window
    input  wire logic [1:0] wave_out,
    input  wire logic       clr,
    input  wire logic       win,
    // measured counts
    output logic [7:0]      rise_cnt [2],
    output logic [7:0]      high_cnt [2]
);
    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    logic [1:0] prev;

    // sampled once per clock; prev runs outside the window so the first edge counts right
    always_ff @(posedge hclk)
    begin
        prev <= wave_out;
        for (int i = 0; i < 2; i++)
        begin
            if (clr)
            begin
                rise_cnt[i] <= 8'h00;
                high_cnt[i] <= 8'h00;
            end
            else if (win)
            begin
                rise_cnt[i] <= rise_cnt[i] + {7'h00, wave_out[i] & ~prev[i]};
                high_cnt[i] <= high_cnt[i] + {7'h00, wave_out[i]};
            end
        end
    end
endmodule
